// >>> host_port_pkg.sv
package host_port_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    // address bit roles
    localparam int FIFO_SEL_BIT = 5;
    localparam int ADDR_BIT0 = 0;
    localparam int ADDR_BIT1 = 1;
    // host offsets with special meaning in 8-bit mode
    localparam logic [ADDR_W-1:0] OFF_CMD_PAGE = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_BURST_CHOICE = 6'h0D;
    localparam logic [ADDR_W-1:0] OFF_DATA_PORT = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_UNUSED = 6'h11;
    localparam logic [ADDR_W-1:0] OFF_LOW_ONLY = 6'h1E;
    localparam logic [ADDR_W-1:0] OFF_RESET = 6'h1F;
    // command/page register fields
    localparam int PAGE_LSB = 6;
    localparam int PAGE_MSB = 7;
    localparam logic [1:0] PAGE_BURST = 2'h3;
    localparam int BCB_BIT = 0;
    // synchronised pin vector layout
    localparam int PIN_DATA_LSB = 0;
    localparam int PIN_ADDR_LSB = 16;
    localparam int PIN_WR = 22;
    localparam int PIN_RD = 23;
    localparam int PIN_CK = 24;
    localparam int PIN_CS = 25;
    localparam int PIN_RSTL = 26;
    localparam int PIN_W = 27;
    // packet word buffer
    localparam logic [1:0] FIFO_DEPTH = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_BURST, ST_WRITE} port_state_e;
endpackage

// >>> host_port_lane_map_burst.sv
`timescale 1ns/1ps
module host_port_lane_map_burst
(
    // system
    input wire logic clk,
    input wire logic rst,
    // host pins
    input wire logic [host_port_pkg::ADDR_W-1:0] host_addr,
    input wire logic read_strobe_low,
    input wire logic write_strobe_low,
    input wire logic [host_port_pkg::DATA_W-1:0] host_data_lanes_in,
    output logic [host_port_pkg::DATA_W-1:0] host_data_lanes_out,
    output logic host_data_lanes_oe,
    // reset and straps
    input wire logic hardware_reset_input_low,
    input wire logic strap_serial_select_pin,
    input wire logic strap_serial_clock_pin,
    // register file lookup
    output logic [host_port_pkg::ADDR_W-1:0] reg_rd_off_lo,
    output logic [host_port_pkg::ADDR_W-1:0] reg_rd_off_hi,
    input wire logic [host_port_pkg::LANE_W-1:0] reg_rd_data_lo,
    input wire logic [host_port_pkg::LANE_W-1:0] reg_rd_data_hi,
    // register write
    output logic reg_wr_stb,
    output logic [host_port_pkg::ADDR_W-1:0] reg_wr_off,
    output logic [host_port_pkg::LANE_W-1:0] reg_wr_data,
    // packet data port, read stream
    input wire logic dp_in_valid,
    input wire logic [host_port_pkg::DATA_W-1:0] dp_in_data,
    output logic dp_in_ready,
    // packet data port, write
    output logic dp_wr_stb,
    output logic [host_port_pkg::LANE_W-1:0] dp_wr_data,
    // status
    output logic ctrl_reset_pulse,
    output logic mode_8bit,
    output logic burst_active,
    output logic burst_toggle_bit_choice
);
    import host_port_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic [PIN_W-1:0] sync3;
        logic [PIN_W-1:0] pins;
        logic rstl_d;
        logic mode8;
        logic [1:0] page;
        logic burst_sel;
        port_state_e state;
        logic tog_d;
        logic oe;
        logic [DATA_W-1:0] rd_word;
        logic [1:0][DATA_W-1:0] fifo;
        logic [1:0] cnt;
        logic rd_idx;
        logic wr_idx;
        logic reg_wr;
        logic [ADDR_W-1:0] wr_off;
        logic [LANE_W-1:0] wr_data;
        logic dp_wr;
        logic soft_rst;
    } state_s;

    state_s q_r;
    state_s q_nxt;

    logic rstl;
    logic rd_n;
    logic wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
    logic rstl_rise;
    logic tog_bit;
    logic have_word;
    logic [DATA_W-1:0] head;
    logic push;
    logic pop;
    logic read_go;
    logic write_go;
    logic write_done;

    // lane placement of a register read; the core already looks up N and N|1
    function automatic logic [DATA_W-1:0] lane_map(input logic [ADDR_W-1:0] a,
                                                   input logic [LANE_W-1:0] lo,
                                                   input logic [LANE_W-1:0] hi);
        logic [DATA_W-1:0] w;
        w = {hi, lo};
        if (a == OFF_UNUSED || a == OFF_RESET)
        begin
            w = '0;
        end
        else if (a == OFF_LOW_ONLY)
        begin
            w = {{LANE_W{1'b0}}, lo};
        end
        return w;
    endfunction

    assign rstl = q_r.pins[PIN_RSTL];
    assign rd_n = q_r.pins[PIN_RD];
    assign wr_n = q_r.pins[PIN_WR];
    assign addr = q_r.pins[PIN_ADDR_LSB +: ADDR_W];
    assign din = q_r.pins[PIN_DATA_LSB +: DATA_W];
    assign rstl_rise = rstl && !q_r.rstl_d;
    assign tog_bit = q_r.burst_sel ? addr[ADDR_BIT1] : addr[ADDR_BIT0];
    assign have_word = q_r.cnt != 2'h0;
    assign head = q_r.fifo[q_r.rd_idx];
    assign dp_in_ready = q_r.cnt != FIFO_DEPTH;
    assign push = dp_in_valid && dp_in_ready;
    assign read_go = q_r.state == ST_IDLE && q_r.mode8 && rstl && !rd_n;
    assign write_go = q_r.state == ST_IDLE && q_r.mode8 && rstl && rd_n && !wr_n;
    assign write_done = q_r.state == ST_WRITE && wr_n && rstl;
    // odd address looks up itself on both lanes
    assign reg_rd_off_lo = addr;
    assign reg_rd_off_hi = {addr[ADDR_W-1:1], 1'b1} & {{(ADDR_W-1){1'b1}}, ~addr[0]}
                           | addr;

    always_comb
    begin
        q_nxt = q_r;
        pop = 1'b0;
        q_nxt.sync1 = {hardware_reset_input_low, strap_serial_select_pin,
                       strap_serial_clock_pin, read_strobe_low, write_strobe_low,
                       host_addr, host_data_lanes_in};
        q_nxt.sync2 = q_r.sync1;
        q_nxt.sync3 = q_r.sync2;
        // a bit moves only once the second and third stages agree
        q_nxt.pins = (q_r.sync2 & ~(q_r.sync2 ^ q_r.sync3))
                     | (q_r.pins & (q_r.sync2 ^ q_r.sync3));
        q_nxt.rstl_d = rstl;
        q_nxt.reg_wr = 1'b0;
        q_nxt.dp_wr = 1'b0;
        q_nxt.soft_rst = 1'b0;
        if (rstl_rise)
        begin
            q_nxt.mode8 = q_r.pins[PIN_CS] & q_r.pins[PIN_CK];
        end
        case (q_r.state)
            ST_IDLE:
            begin
                if (read_go)
                begin
                    q_nxt.oe = 1'b1;
                    if (addr[FIFO_SEL_BIT])
                    begin
                        q_nxt.state = ST_BURST;
                        q_nxt.tog_d = tog_bit;
                        pop = have_word;
                        q_nxt.rd_word = have_word ? head : '0;
                    end
                    else
                    begin
                        q_nxt.state = ST_READ;
                        q_nxt.rd_word = lane_map(addr, reg_rd_data_lo, reg_rd_data_hi);
                        if (addr == OFF_DATA_PORT)
                        begin
                            pop = have_word;
                            q_nxt.rd_word = have_word ? head : '0;
                        end
                        q_nxt.soft_rst = addr == OFF_RESET;
                    end
                end
                else if (write_go)
                begin
                    q_nxt.state = ST_WRITE;
                    q_nxt.wr_off = addr;
                    q_nxt.wr_data = din[LANE_W-1:0];
                end
            end
            ST_READ:
            begin
                // the word stays put until the strobe rises: one access per pulse
                if (rd_n)
                begin
                    q_nxt.state = ST_IDLE;
                    q_nxt.oe = 1'b0;
                end
            end
            ST_BURST:
            begin
                if (rd_n)
                begin
                    q_nxt.state = ST_IDLE;
                    q_nxt.oe = 1'b0;
                end
                else if (tog_bit != q_r.tog_d)
                begin
                    // the strobe may stay low; only the address toggle marks a word
                    q_nxt.tog_d = tog_bit;
                    pop = have_word;
                    q_nxt.rd_word = have_word ? head : '0;
                end
            end
            ST_WRITE:
            begin
                if (!wr_n)
                begin
                    q_nxt.wr_off = addr;
                    q_nxt.wr_data = din[LANE_W-1:0];
                end
                else
                begin
                    q_nxt.state = ST_IDLE;
                    if (!q_r.wr_off[FIFO_SEL_BIT])
                    begin
                        if (q_r.wr_off == OFF_DATA_PORT)
                        begin
                            q_nxt.dp_wr = 1'b1;
                        end
                        else if (q_r.wr_off != OFF_UNUSED)
                        begin
                            q_nxt.reg_wr = 1'b1;
                        end
                        if (q_r.wr_off == OFF_CMD_PAGE)
                        begin
                            q_nxt.page = q_r.wr_data[PAGE_MSB:PAGE_LSB];
                        end
                        if (q_r.wr_off == OFF_BURST_CHOICE && q_r.page == PAGE_BURST)
                        begin
                            q_nxt.burst_sel = q_r.wr_data[BCB_BIT];
                        end
                    end
                end
            end
            default:
            begin
                q_nxt.state = ST_IDLE;
                q_nxt.oe = 1'b0;
            end
        endcase
        // two-entry word buffer between the packet stream and the host
        if (push)
        begin
            q_nxt.fifo[q_r.wr_idx] = dp_in_data;
            q_nxt.wr_idx = ~q_r.wr_idx;
        end
        if (pop)
        begin
            q_nxt.rd_idx = ~q_r.rd_idx;
        end
        q_nxt.cnt = q_r.cnt + {1'b0, push} - {1'b0, pop};
        // hardware reset held low: port goes quiet and page state is lost
        if (!rstl)
        begin
            q_nxt.state = ST_IDLE;
            q_nxt.oe = 1'b0;
            q_nxt.page = 2'h0;
            q_nxt.burst_sel = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q_r <= '0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign host_data_lanes_out = q_r.rd_word;
    assign host_data_lanes_oe = q_r.oe;
    assign reg_wr_stb = q_r.reg_wr;
    assign reg_wr_off = q_r.wr_off;
    assign reg_wr_data = q_r.wr_data;
    assign dp_wr_stb = q_r.dp_wr;
    assign dp_wr_data = q_r.wr_data;
    assign ctrl_reset_pulse = q_r.soft_rst;
    assign mode_8bit = q_r.mode8;
    assign burst_active = q_r.state == ST_BURST;
    assign burst_toggle_bit_choice = q_r.burst_sel;

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_burst_start;
        read_go && addr[FIFO_SEL_BIT];
    endsequence

    sequence s_reg_start;
        read_go && !addr[FIFO_SEL_BIT];
    endsequence

    sequence s_choice_write;
        write_done && q_r.wr_off == OFF_BURST_CHOICE && q_r.page == PAGE_BURST;
    endsequence

    burst_entry_a: assert property (s_burst_start |=> burst_active && host_data_lanes_oe)
        else $error("fifo-select read did not enter burst");
    reg_entry_a: assert property (s_reg_start |=> q_r.state == ST_READ ##1 !burst_active)
        else $error("register read entered burst");
    burst_word_a: assert property (burst_active && !rd_n && tog_bit != q_r.tog_d && have_word
        |=> host_data_lanes_out == $past(head) && burst_active)
        else $error("burst toggle did not return next word");
    strobe_no_pop_a: assert property (q_r.state == ST_BURST && tog_bit == q_r.tog_d |-> !pop)
        else $error("burst word taken without address toggle");
    toggle_choice_a: assert property (s_choice_write |=> burst_toggle_bit_choice
        == $past(q_r.wr_data[BCB_BIT]))
        else $error("burst toggle choice not stored");
    strap_mode_a: assert property (rstl_rise |=> mode_8bit == $past(q_r.pins[PIN_CS]
        && q_r.pins[PIN_CK]))
        else $error("bus mode not taken from straps");
    mode_hold_a: assert property (!rstl_rise |=> $stable(mode_8bit))
        else $error("bus mode changed away from reset edge");
    even_read_a: assert property (s_reg_start and (!addr[0] && addr != OFF_DATA_PORT
        && addr != OFF_LOW_ONLY)
        |=> host_data_lanes_out == {$past(reg_rd_data_hi), $past(reg_rd_data_lo)})
        else $error("even read lane placement wrong");
    odd_offset_a: assert property (addr[0] |-> reg_rd_off_hi == addr && reg_rd_off_lo == addr)
        else $error("odd address must look up itself on both lanes");
    write_low_a: assert property (write_done && !q_r.wr_off[FIFO_SEL_BIT] && q_r.wr_off
        < OFF_DATA_PORT |=> reg_wr_stb && reg_wr_data == $past(q_r.wr_data) ##1 !reg_wr_stb)
        else $error("register write not a single low-lane strobe");
    dp_write_a: assert property (write_done && q_r.wr_off == OFF_DATA_PORT
        |=> dp_wr_stb && !reg_wr_stb)
        else $error("data port write misrouted");
    low_only_a: assert property (s_reg_start and (addr == OFF_LOW_ONLY)
        |=> host_data_lanes_out[DATA_W-1:LANE_W] == '0)
        else $error("high lane of offset 1E not quiet");
    reset_read_a: assert property (s_reg_start and (addr == OFF_RESET)
        |=> ctrl_reset_pulse ##1 !ctrl_reset_pulse)
        else $error("read of 1F did not pulse controller reset");
endmodule // host_port_lane_map_burst

// >>> core_model.sv
`timescale 1ns/1ps
module core_model
(
    // system
    input wire logic clk,
    input wire logic rst,
    input wire logic src_en,
    // register lookup
    input wire logic [host_port_pkg::ADDR_W-1:0] rd_off_lo,
    input wire logic [host_port_pkg::ADDR_W-1:0] rd_off_hi,
    output logic [host_port_pkg::LANE_W-1:0] rd_data_lo,
    output logic [host_port_pkg::LANE_W-1:0] rd_data_hi,
    // packet word source
    output logic src_valid,
    output logic [host_port_pkg::DATA_W-1:0] src_data,
    input wire logic src_ready
);
    import host_port_pkg::*;
    logic [DATA_W-1:0] word_r;
    // offset shows in the byte so a wrong lane mapping gives a wrong value
    assign rd_data_lo = {2'h2, rd_off_lo};
    assign rd_data_hi = {2'h2, rd_off_hi};
    assign src_valid = src_en;
    // words count up so a lost or doubled pop shows as a wrong value
    assign src_data = src_en ? word_r : ~word_r;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            word_r <= 16'h1000;
        else if (src_en && src_ready)
            word_r <= word_r + 16'h0001;
    end
endmodule // core_model

// >>> tb_host_port_lane_map_burst.sv
`timescale 1ns/1ps
module tb_host_port_lane_map_burst;
    import host_port_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] host_addr = 6'h00;
    logic read_strobe_low = 1'b1;
    logic write_strobe_low = 1'b1;
    logic [DATA_W-1:0] host_data_lanes_in = 16'h0000;
    logic [DATA_W-1:0] host_data_lanes_out;
    logic host_data_lanes_oe;
    logic hardware_reset_input_low = 1'b0;
    logic strap_serial_select_pin = 1'b1;
    logic strap_serial_clock_pin = 1'b1;
    logic [ADDR_W-1:0] reg_rd_off_lo, reg_rd_off_hi, reg_wr_off;
    logic [LANE_W-1:0] reg_rd_data_lo, reg_rd_data_hi, reg_wr_data, dp_wr_data;
    logic reg_wr_stb, dp_in_valid, dp_in_ready, dp_wr_stb, ctrl_reset_pulse;
    logic [DATA_W-1:0] dp_in_data;
    logic mode_8bit, burst_active, burst_toggle_bit_choice;
    logic src_en = 1'b0;
    logic [ADDR_W-1:0] seen_off = 6'h00;
    logic [LANE_W-1:0] seen_data = 8'h00;
    logic [LANE_W-1:0] seen_dp = 8'h00;
    int pulse_cnt = 0;
    int err_count = 0;
    int tests_run = 0;
    always #12.5 clk = ~clk;
    host_port_lane_map_burst DUT (.clk(clk), .rst(rst), .host_addr(host_addr),
        .read_strobe_low(read_strobe_low), .write_strobe_low(write_strobe_low),
        .host_data_lanes_in(host_data_lanes_in), .host_data_lanes_out(host_data_lanes_out),
        .host_data_lanes_oe(host_data_lanes_oe),
        .hardware_reset_input_low(hardware_reset_input_low),
        .strap_serial_select_pin(strap_serial_select_pin),
        .strap_serial_clock_pin(strap_serial_clock_pin),
        .reg_rd_off_lo(reg_rd_off_lo), .reg_rd_off_hi(reg_rd_off_hi),
        .reg_rd_data_lo(reg_rd_data_lo), .reg_rd_data_hi(reg_rd_data_hi),
        .reg_wr_stb(reg_wr_stb), .reg_wr_off(reg_wr_off), .reg_wr_data(reg_wr_data),
        .dp_in_valid(dp_in_valid), .dp_in_data(dp_in_data), .dp_in_ready(dp_in_ready),
        .dp_wr_stb(dp_wr_stb), .dp_wr_data(dp_wr_data), .ctrl_reset_pulse(ctrl_reset_pulse),
        .mode_8bit(mode_8bit), .burst_active(burst_active),
        .burst_toggle_bit_choice(burst_toggle_bit_choice));
    core_model partner (.clk(clk), .rst(rst), .src_en(src_en), .rd_off_lo(reg_rd_off_lo),
        .rd_off_hi(reg_rd_off_hi), .rd_data_lo(reg_rd_data_lo), .rd_data_hi(reg_rd_data_hi),
        .src_valid(dp_in_valid), .src_data(dp_in_data), .src_ready(dp_in_ready));
    // strobes are one clock wide, so latch them as they pass
    always @(posedge clk)
    begin
        if (reg_wr_stb)
        begin
            seen_off <= reg_wr_off;
            seen_data <= reg_wr_data;
        end
        if (dp_wr_stb)
            seen_dp <= dp_wr_data;
        if (ctrl_reset_pulse)
            pulse_cnt <= pulse_cnt + 1;
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // the pin filter needs about four clocks, so six gives margin
    task automatic host_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        host_addr = a;
        read_strobe_low = 1'b0;
        wait_n(6);
        d = host_data_lanes_out;
        chk({15'h0000, host_data_lanes_oe}, 16'h0001);
        read_strobe_low = 1'b1;
        wait_n(6);
        chk({15'h0000, host_data_lanes_oe}, 16'h0000);
    endtask
    task automatic host_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        host_addr = a;
        host_data_lanes_in = d;
        write_strobe_low = 1'b0;
        wait_n(6);
        write_strobe_low = 1'b1;
        wait_n(6);
    endtask
    task automatic test_straps();
        wait_n(8);
        chk({15'h0000, mode_8bit}, 16'h0001);
        strap_serial_select_pin = 1'b0;
        wait_n(6);
        chk({15'h0000, mode_8bit}, 16'h0001);
        $display("test straps done");
    endtask
    task automatic test_lanes();
        logic [ADDR_W-1:0] a [5] = '{6'h12, 6'h13, 6'h1E, 6'h11, 6'h01};
        logic [DATA_W-1:0] e [5] = '{16'h9392, 16'h9393, 16'h009E, 16'h0000, 16'h8181};
        logic [DATA_W-1:0] d;
        for (int i = 0; i < 5; i++)
        begin
            host_read(a[i], d);
            chk(d, e[i]);
        end
        host_read(OFF_RESET, d);
        chk(d, 16'h0000);
        chk(16'(pulse_cnt), 16'h0001);
        $display("test lanes done");
    endtask
    task automatic test_writes();
        host_write(6'h0C, 16'hFF37);
        chk({10'h000, seen_off}, 16'h000C);
        chk({8'h00, seen_data}, 16'h0037);
        host_write(OFF_DATA_PORT, 16'hEE55);
        chk({8'h00, seen_dp}, 16'h0055);
        chk({10'h000, seen_off}, 16'h000C);
        // page is still 0 here, so the choice write must not land
        host_write(OFF_BURST_CHOICE, 16'h0001);
        chk({15'h0000, burst_toggle_bit_choice}, 16'h0000);
        host_write(OFF_CMD_PAGE, 16'h00C0);
        host_write(OFF_BURST_CHOICE, 16'h0001);
        chk({15'h0000, burst_toggle_bit_choice}, 16'h0001);
        $display("test writes done");
    endtask
    task automatic test_burst();
        logic [DATA_W-1:0] d;
        src_en = 1'b1;
        wait_n(6);
        chk({15'h0000, dp_in_ready}, 16'h0000);
        host_read(OFF_DATA_PORT, d);
        chk(d, 16'h1000);
        host_addr = 6'h20;
        read_strobe_low = 1'b0;
        wait_n(6);
        chk(host_data_lanes_out, 16'h1001);
        chk({15'h0000, burst_active}, 16'h0001);
        host_addr = 6'h21;
        wait_n(6);
        chk(host_data_lanes_out, 16'h1001);
        for (int i = 0; i < 4; i++)
        begin
            host_addr = host_addr ^ 6'h02;
            wait_n(6);
            chk(host_data_lanes_out, 16'h1002 + 16'(i));
        end
        read_strobe_low = 1'b1;
        wait_n(6);
        chk({15'h0000, burst_active}, 16'h0000);
        $display("test burst done");
    endtask
    // buffer holds 1006 and 1007 on entry; bit 1 must now be ignored
    task automatic test_burst_bit0();
        host_write(OFF_BURST_CHOICE, 16'h0000);
        chk({15'h0000, burst_toggle_bit_choice}, 16'h0000);
        host_addr = 6'h20;
        read_strobe_low = 1'b0;
        wait_n(6);
        chk(host_data_lanes_out, 16'h1006);
        host_addr = 6'h22;
        wait_n(6);
        chk(host_data_lanes_out, 16'h1006);
        host_addr = 6'h23;
        wait_n(6);
        chk(host_data_lanes_out, 16'h1007);
        read_strobe_low = 1'b1;
        wait_n(6);
        chk({15'h0000, burst_active}, 16'h0000);
        $display("test burst bit0 done");
    endtask
    initial
    begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        wait_n(2);
        hardware_reset_input_low = 1'b1;
        test_straps();
        test_lanes();
        test_writes();
        test_burst();
        test_burst_bit0();
        report_and_stop();
    end
    initial
    begin
        #(25 * 3000);
        err_count++;
        report_and_stop();
    end
endmodule // tb_host_port_lane_map_burst
